/* rtl/downstream_window3_base_register.sv */
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps

module downstream_window3_base_register (
  input wire logic ref_clk,
  input wire logic srst,
  input wire window3_pkg::apb_req_s apb_req,
  output window3_pkg::apb_rsp_s apb_rsp,
  input wire window3_pkg::fwd_req_s fwd_req,
  output window3_pkg::fwd_rsp_s fwd_rsp
);

  typedef struct packed {
    logic [31:0] setup_lo;
    logic [31:0] setup_hi;
    logic [31:0] xlat;
    logic [31:0] prdata;
    logic claim;
    logic [63:0] claim_addr;
    logic [15:0] claim_count;
  } state_s;

  state_s state;
  state_s next_state;

  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic addr_mapped;
  logic wr_base;
  logic wr_upper;
  logic wr_status;
  logic [19:0] lo_mask;
  logic [31:0] hi_mask;
  logic [19:0] base_lo;
  logic [31:0] base_hi;
  logic [1:0] addr_type;
  logic is64;
  logic prefetch;
  logic enabled;
  logic lo_match;
  logic hi_match;
  logic hit;
  logic [31:0] base_word;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic [63:0] out_addr;

  // ==========================================================
  // apb phase decode
  assign setup_phase = apb_req.psel & ~apb_req.penable;
  assign access_phase = apb_req.psel & apb_req.penable;
  assign wr_access = access_phase & apb_req.pwrite;

  always_comb
  begin
    if (apb_req.paddr == window3_pkg::BASE_OFS)
    begin
      addr_mapped = 1'b1;
    end
    else if (apb_req.paddr == window3_pkg::UPPER_OFS)
    begin
      addr_mapped = 1'b1;
    end
    else if (apb_req.paddr == window3_pkg::XLAT_OFS)
    begin
      addr_mapped = 1'b1;
    end
    else if (apb_req.paddr == window3_pkg::SETUP_LO_OFS)
    begin
      addr_mapped = 1'b1;
    end
    else if (apb_req.paddr == window3_pkg::SETUP_HI_OFS)
    begin
      addr_mapped = 1'b1;
    end
    else if (apb_req.paddr == window3_pkg::STATUS_OFS)
    begin
      addr_mapped = 1'b1;
    end
    else
    begin
      addr_mapped = 1'b0;
    end
  end

  // ==========================================================
  // write strobes
  // base and upper feed the masked fields
  always_comb
  begin
    wr_base = 1'b0;
    wr_upper = 1'b0;
    wr_status = 1'b0;
    if (wr_access)
    begin
      if (apb_req.paddr == window3_pkg::BASE_OFS)
      begin
        wr_base = 1'b1;
      end
      else if (apb_req.paddr == window3_pkg::UPPER_OFS)
      begin
        wr_upper = 1'b1;
      end
      else if (apb_req.paddr == window3_pkg::STATUS_OFS)
      begin
        // status write clears the claim counter
        wr_status = 1'b1;
      end
    end
  end

  // ==========================================================
  // window shape from setup registers
  // size mask and type from setup
  assign lo_mask = state.setup_lo[31:window3_pkg::BASE_LSB];
  assign hi_mask = state.setup_hi;
  assign addr_type = state.setup_lo[window3_pkg::TYPE_MSB:window3_pkg::TYPE_LSB];
  assign is64 = (addr_type == window3_pkg::TYPE_64);
  assign prefetch = state.setup_lo[window3_pkg::PREF_BIT];
  // enable bit of lower setup, or of upper setup in 64-bit type
  assign enabled = state.setup_lo[window3_pkg::ENABLE_BIT]
                   | (is64 & state.setup_hi[window3_pkg::ENABLE_BIT]);

  // ==========================================================
  // base address fields
  // masked lower base bits
  masked_field #(
    .W(window3_pkg::LO_W),
    .RST(window3_pkg::BASE_RST)
  ) u_base_lo (
    .ref_clk(ref_clk),
    .srst(srst),
    .wr_en(wr_base),
    .wr_data(apb_req.pwdata[31:window3_pkg::BASE_LSB]),
    .mask(lo_mask),
    .value(base_lo)
  );

  masked_field #(
    .W(window3_pkg::HI_W),
    .RST(window3_pkg::UPPER_RST)
  ) u_base_hi (
    .ref_clk(ref_clk),
    .srst(srst),
    .wr_en(wr_upper),
    .wr_data(apb_req.pwdata),
    .mask(hi_mask),
    .value(base_hi)
  );

  assign base_word = {base_lo, window3_pkg::RSVD_VALUE, prefetch, addr_type, 1'b0};
  assign status_word = {14'h0000, is64, enabled, state.claim_count};

  // ==========================================================
  // read mux
  always_comb
  begin
    if (apb_req.paddr == window3_pkg::BASE_OFS)
    begin
      rd_word = base_word;
    end
    else if (apb_req.paddr == window3_pkg::UPPER_OFS)
    begin
      rd_word = base_hi;
    end
    else if (apb_req.paddr == window3_pkg::XLAT_OFS)
    begin
      rd_word = state.xlat;
    end
    else if (apb_req.paddr == window3_pkg::SETUP_LO_OFS)
    begin
      rd_word = state.setup_lo;
    end
    else if (apb_req.paddr == window3_pkg::SETUP_HI_OFS)
    begin
      rd_word = state.setup_hi;
    end
    else if (apb_req.paddr == window3_pkg::STATUS_OFS)
    begin
      rd_word = status_word;
    end
    else
    begin
      rd_word = 32'h00000000;
    end
  end

  // ==========================================================
  // forwarding decode
  // mask spans 4KB granule to full 64 bits in 64-bit type, to bit 31 otherwise
  assign lo_match = ((fwd_req.addr[31:window3_pkg::BASE_LSB] & lo_mask) == base_lo);
  assign hi_match = is64 ? ((fwd_req.addr[63:32] & hi_mask) == base_hi)
                         : (fwd_req.addr[63:32] == 32'h00000000);
  assign hit = fwd_req.valid & enabled & lo_match & hi_match;

  always_comb
  begin
    if (is64)
    begin
      out_addr = fwd_req.addr;
    end
    else
    begin
      out_addr = {32'h00000000,
                  (state.xlat[31:window3_pkg::BASE_LSB] & lo_mask)
                  | (fwd_req.addr[31:window3_pkg::BASE_LSB] & ~lo_mask),
                  fwd_req.addr[window3_pkg::BASE_LSB-1:0]};
    end
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_state = state;
    if (setup_phase)
    begin
      next_state.prdata = rd_word;
    end
    if (wr_access)
    begin
      if (apb_req.paddr == window3_pkg::XLAT_OFS)
      begin
        next_state.xlat = apb_req.pwdata;
      end
      else if (apb_req.paddr == window3_pkg::SETUP_LO_OFS)
      begin
        // memory only: space bit and reserved bits stay zero
        next_state.setup_lo = apb_req.pwdata & window3_pkg::SETUP_LO_KEEP;
      end
      else if (apb_req.paddr == window3_pkg::SETUP_HI_OFS)
      begin
        next_state.setup_hi = apb_req.pwdata;
      end
      else if (apb_req.paddr == window3_pkg::STATUS_OFS)
      begin
        // any write clears the claim counter
        next_state.claim_count = window3_pkg::COUNT_RST;
      end
    end
    next_state.claim = hit;
    if (hit)
    begin
      next_state.claim_addr = out_addr;
      if (!wr_status)
      begin
        next_state.claim_count = state.claim_count + 16'h0001;
      end
      else
      begin
        // a claim in the clearing cycle still counts
        next_state.claim_count = 16'h0001;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state.setup_lo <= window3_pkg::SETUP_RST;
      state.setup_hi <= window3_pkg::SETUP_RST;
      state.xlat <= window3_pkg::XLAT_RST;
      state.prdata <= 32'h00000000;
      state.claim <= 1'b0;
      state.claim_addr <= 64'h0000000000000000;
      state.claim_count <= window3_pkg::COUNT_RST;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs, packed in carrier field order
  // pready tracks the access phase: no wait states
  assign apb_rsp = {access_phase,
                    access_phase & ~addr_mapped,
                    state.prdata};
  assign fwd_rsp = {state.claim,
                    state.claim_addr};

endmodule : downstream_window3_base_register

/* rtl/masked_field.sv */
`timescale 1ns/10ps

// ==========================================================
// base-address field whose bits are writable only under mask
module masked_field #(
  parameter int W = 20,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  input wire logic [W-1:0] mask,
  output logic [W-1:0] value
);

  typedef struct packed {
    logic [W-1:0] stored;
  } field_s;

  field_s state;
  field_s next_state;

  always_comb
  begin
    next_state = state;
    if (wr_en)
    begin
      next_state.stored = wr_data & mask;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state.stored <= RST;
    end
    else
    begin
      state <= next_state;
    end
  end

  // unmasked bits read as zero even if mask shrinks later
  assign value = state.stored & mask;

endmodule : masked_field

/* rtl/window3_pkg.sv */
package window3_pkg;

  // ==========================================================
  // register map, byte addresses
  localparam logic [11:0] BASE_OFS = 12'h020;
  localparam logic [11:0] UPPER_OFS = 12'h024;
  localparam logic [11:0] XLAT_OFS = 12'h110;
  localparam logic [11:0] SETUP_LO_OFS = 12'h114;
  localparam logic [11:0] SETUP_HI_OFS = 12'h118;
  localparam logic [11:0] STATUS_OFS = 12'h11c;

  // ==========================================================
  // field positions
  localparam int SPACE_BIT = 0;
  localparam int TYPE_LSB = 1;
  localparam int TYPE_MSB = 2;
  localparam int PREF_BIT = 3;
  localparam int BASE_LSB = 12;
  localparam int ENABLE_BIT = 31;
  localparam int LO_W = 20;
  localparam int HI_W = 32;

  // ==========================================================
  // encodings and reset values
  localparam logic [1:0] TYPE_32 = 2'h0;
  localparam logic [1:0] TYPE_64 = 2'h1;
  localparam logic [1:0] TYPE_RST = 2'h0;
  localparam logic PREF_RST = 1'h0;
  localparam logic [19:0] BASE_RST = 20'h00000;
  localparam logic [31:0] UPPER_RST = 32'h00000000;
  localparam logic [31:0] SETUP_RST = 32'h00000000;
  localparam logic [31:0] XLAT_RST = 32'h00000000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0] RSVD_VALUE = 8'h00;
  // setup low: bits that can hold a value (mask, prefetch, type)
  localparam logic [31:0] SETUP_LO_KEEP = 32'hfffff00e;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

  typedef struct packed {
    logic valid;
    logic [63:0] addr;
  } fwd_req_s;

  typedef struct packed {
    logic claim;
    logic [63:0] addr;
  } fwd_rsp_s;

endpackage : window3_pkg

/* verification/downstream_window3_base_register_assertions.sv */
`timescale 1ns/10ps

// ==========================================================
// port checks
module downstream_window3_base_register_assertions (
  input wire logic ref_clk,
  input wire logic srst,
  input wire window3_pkg::apb_req_s apb_req,
  input wire window3_pkg::apb_rsp_s apb_rsp,
  input wire window3_pkg::fwd_req_s fwd_req,
  input wire window3_pkg::fwd_rsp_s fwd_rsp
);
  logic acc;
  assign acc = apb_req.psel && apb_req.penable;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  a_ready_access: assert property (apb_rsp.pready == acc)
    else $error("pready differs from access phase");
  a_err_access: assert property (apb_rsp.pslverr |-> acc)
    else $error("pslverr outside access phase");
  a_base_reserved_zero: assert property (acc && !apb_req.pwrite &&
    apb_req.paddr == window3_pkg::BASE_OFS |-> apb_rsp.prdata[11:4] == 8'h00 && !apb_rsp.prdata[0])
    else $error("base reserved bits not zero");
  a_rdata_stands: assert property (!(apb_req.psel && !apb_req.penable) && !$past(srst)
    |=> $stable(apb_rsp.prdata))
    else $error("read data changed outside setup");
  a_claim_cause: assert property (fwd_rsp.claim |-> $past(fwd_req.valid))
    else $error("claim without lookup");
  a_fwd_addr_hold: assert property (!fwd_rsp.claim && !$past(srst) |-> $stable(fwd_rsp.addr))
    else $error("forwarded address moved without claim");
  a_low_bits_kept: assert property (fwd_rsp.claim |->
    fwd_rsp.addr[11:0] == $past(fwd_req.addr[11:0]))
    else $error("page offset altered");
  a_wide_untranslated: assert property (fwd_rsp.claim &&
    $past(fwd_req.addr[63:32]) != 32'h0 |-> fwd_rsp.addr == $past(fwd_req.addr))
    else $error("wide address translated");

  c_claim: cover property (fwd_rsp.claim);
  c_err: cover property (apb_rsp.pslverr);
  c_base_wr: cover property (acc && apb_req.pwrite && apb_req.paddr == window3_pkg::BASE_OFS);
endmodule : downstream_window3_base_register_assertions

bind downstream_window3_base_register downstream_window3_base_register_assertions i_chk (
  .ref_clk(ref_clk), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .fwd_req(fwd_req), .fwd_rsp(fwd_rsp));

/* verification/downstream_window3_base_register_bench.sv */
`timescale 1ns/10ps

// ==========================================================
// bench top
module downstream_window3_base_register_bench;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  window3_pkg::apb_req_s apb_req = '0;
  window3_pkg::apb_rsp_s apb_rsp;
  window3_pkg::fwd_req_s fwd_req = '0;
  window3_pkg::fwd_rsp_s fwd_rsp;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  always #5 ref_clk = ~ref_clk;

  downstream_window3_base_register i_downstream_window3_base_register (
    .ref_clk(ref_clk), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .fwd_req(fwd_req), .fwd_rsp(fwd_rsp));

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      fail_count++;
      close_out();
    end
  end

  task check(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : check

  // ==========================================================
  // apb master
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge ref_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do @(posedge ref_clk); while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    check("write error", 64'h0, {63'h0, e});
  endtask : wr

  task rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(what, {32'h0, exp}, {32'h0, q});
    check("read error", 64'h0, {63'h0, e});
  endtask : rd

  task look(input logic [63:0] a, input logic hit, input logic [63:0] out);
    @(posedge ref_clk);
    fwd_req <= '{valid: 1'b1, addr: a};
    @(posedge ref_clk);
    fwd_req.valid <= 1'b0;
    @(posedge ref_clk);
    check("claim", {63'h0, hit}, {63'h0, fwd_rsp.claim});
    if (hit)
      check("forwarded address", out, fwd_rsp.addr);
  endtask : look

  // ==========================================================
  // scenarios
  task s_mask;
    rd("base reset", window3_pkg::BASE_OFS, 32'h0);
    rd("upper reset", window3_pkg::UPPER_OFS, 32'h0);
    wr(window3_pkg::SETUP_LO_OFS, 32'hffff_f00a);
    wr(window3_pkg::BASE_OFS, 32'hffff_ffff);
    rd("base full mask", window3_pkg::BASE_OFS, 32'hffff_f00a);
    wr(window3_pkg::SETUP_LO_OFS, 32'hfff0_0000);
    rd("base narrowed", window3_pkg::BASE_OFS, 32'hfff0_0000);
  endtask : s_mask

  task s_narrow;
    wr(window3_pkg::BASE_OFS, 32'h1234_5fff);
    rd("base masked", window3_pkg::BASE_OFS, 32'h1230_0000);
    wr(window3_pkg::XLAT_OFS, 32'habcd_e000);
    look(64'h0000_0000_1234_5678, 1'b1, 64'h0000_0000_abc4_5678);
    look(64'h0000_0000_1244_5678, 1'b0, 64'h0);
    look(64'h0000_0001_1234_5678, 1'b0, 64'h0);
    wr(window3_pkg::SETUP_LO_OFS, 32'h7ff0_0000);
    look(64'h0000_0000_1234_5678, 1'b0, 64'h0);
  endtask : s_narrow

  task s_wide;
    logic [31:0] q;
    logic e;
    wr(window3_pkg::SETUP_LO_OFS, 32'hfff0_0002);
    wr(window3_pkg::SETUP_HI_OFS, 32'h0000_00ff);
    wr(window3_pkg::UPPER_OFS, 32'hffff_ff05);
    rd("upper masked", window3_pkg::UPPER_OFS, 32'h0000_0005);
    rd("base wide type", window3_pkg::BASE_OFS, 32'h1230_0002);
    look(64'h0000_0005_1234_5678, 1'b1, 64'h0000_0005_1234_5678);
    look(64'h0000_0006_1234_5678, 1'b0, 64'h0);
    wr(window3_pkg::SETUP_LO_OFS, 32'h7ff0_0002);
    look(64'h0000_0005_1234_5678, 1'b0, 64'h0);
    rd("status disabled", window3_pkg::STATUS_OFS, 32'h0002_0002);
    wr(window3_pkg::SETUP_HI_OFS, 32'h8000_00ff);
    look(64'h0000_0005_1234_5678, 1'b1, 64'h0000_0005_1234_5678);
    rd("status enabled", window3_pkg::STATUS_OFS, 32'h0003_0003);
    wr(window3_pkg::STATUS_OFS, 32'h0);
    rd("status cleared", window3_pkg::STATUS_OFS, 32'h0003_0000);
    apb(1'b0, 12'h028, 32'h0, q, e);
    check("unmapped error", 64'h1, {63'h0, e});
    check("unmapped data", 64'h0, {32'h0, q});
  endtask : s_wide

  initial
  begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    s_mask();
    s_narrow();
    s_wide();
    close_out();
  end
endmodule : downstream_window3_base_register_bench
